//--- hdl/completion_entry_poster_defines.vh
// constants for the completion entry poster
`ifndef COMPLETION_ENTRY_POSTER_DEFINES_VH
`define COMPLETION_ENTRY_POSTER_DEFINES_VH
// ----------------------------------------------------------------------
// entry geometry
// ----------------------------------------------------------------------
`define ENTRY_BYTES        16
`define ENTRY_DWORDS       4
`define DWORD_W            32
`define ENTRY_W            128
`define DW_IDX_W           2
`define DW_LAST            2'h3
// ----------------------------------------------------------------------
// dword 2 and dword 3 fields
// ----------------------------------------------------------------------
`define QID_HI             31
`define QID_LO             16
`define HEAD_HI            15
`define HEAD_LO            0
`define STATUS_HI          31
`define STATUS_LO          17
`define PHASE_BIT          16
`define TAG_HI             15
`define TAG_LO             0
`define TAG_W              16
`define QID_W              16
`define STATUS_W           15
// ----------------------------------------------------------------------
// status field layout, relative to status bit 0 (dword 3 bit 17)
// ----------------------------------------------------------------------
`define NO_RETRY_POS       14
`define MORE_LOG_POS       13
`define KIND_HI            10
`define KIND_LO            8
`define DETAIL_HI          7
`define DETAIL_LO          0
`define KIND_W             3
`define DETAIL_W           8
`define DETAIL_SRC         4
`define STATUS_OK          15'h0000
`define DETAIL_NONE        8'hFF
// ----------------------------------------------------------------------
// ring and buffering
// ----------------------------------------------------------------------
`define SLOT_W             16
`define SLOT_ZERO          16'h0000
`define FIFO_DEPTH         4
`define FIFO_AW            2
`define ZERO_DW            32'h00000000
`endif

//--- hdl/entry_fifo.v
// small valid/ready fifo holding whole completion entries
module entry_fifo #(
    parameter WIDTH = 128,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             sys_clk_in,
    input  wire             rstn_in,
    input  wire [WIDTH-1:0] wr_data_in,
    input  wire             wr_valid_in,
    output wire             wr_ready_out,
    output wire [WIDTH-1:0] rd_data_out,
    output wire             rd_valid_out,
    input  wire             rd_ready_in
);
    // ------------------------------------------------------------------
    // storage and pointers
    // ------------------------------------------------------------------
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0]    wptr_q;
    reg [AW-1:0]    rptr_q;
    reg [AW:0]      count_q;
    wire            push;
    wire            pop;

    // honest flags straight from the occupancy count
    assign wr_ready_out = (count_q != DEPTH[AW:0]);
    assign rd_valid_out = (count_q != {(AW+1){1'b0}});
    assign rd_data_out  = mem_q[rptr_q];
    assign push         = wr_valid_in & wr_ready_out;
    assign pop          = rd_valid_out & rd_ready_in;

    // pointers wrap naturally since depth is a power of two
    always @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            wptr_q  <= {AW{1'b0}};
            rptr_q  <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wptr_q <= wptr_q + 1'b1;
            end
            if (pop) begin
                rptr_q <= rptr_q + 1'b1;
            end
            if (push & ~pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop & ~push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end

    // data array needs no reset
    always @(posedge sys_clk_in) begin
        if (push) begin
            mem_q[wptr_q] <= wr_data_in;
        end
    end
endmodule

//--- hdl/completion_entry_poster.v
// completion entry builder and ring poster with phase tracking
// Operation
// - entry is four dwords, sixteen bytes
// - dword0 result only if defined; dword1 reserved
// - dword2 high half carries issuing queue id
// - dword2 low half carries head snapshot
// - dword3 bits 31:17 carry status
// - phase inverts per pass; first pass one
// - after wrap post zero, keep flipping
// - echo host command tag in dword3 low
// - sixteen bit tags allow 64K outstanding
// - success reports all zero status field
// - status subfields at fixed dword3 positions
// - several detail codes: report lowest value
`include "completion_entry_poster_defines.vh"
module completion_entry_poster (
    input  wire                    sys_clk_in,
    input  wire                    rstn_in,
    input  wire                    run_bit_in,
    input  wire [`SLOT_W-1:0]      ring_last_slot_in,
    input  wire                    cpl_valid_in,
    output wire                    cpl_ready_out,
    input  wire                    cpl_has_result_in,
    input  wire [`DWORD_W-1:0]     cpl_result_in,
    input  wire [`QID_W-1:0]       issuing_queue_id_in,
    input  wire [`SLOT_W-1:0]      queue_head_snapshot_in,
    input  wire [`TAG_W-1:0]       command_tag_in,
    input  wire                    cpl_failed_in,
    input  wire                    no_retry_hint_in,
    input  wire                    more_log_in,
    input  wire [`KIND_W-1:0]      status_kind_in,
    input  wire [`DETAIL_SRC-1:0]  detail_hit_in,
    input  wire [`DETAIL_SRC*`DETAIL_W-1:0] detail_codes_in,
    output reg                     mem_wr_valid_out,
    input  wire                    mem_wr_ready_in,
    output reg  [`SLOT_W-1:0]      mem_wr_slot_out,
    output reg  [`DW_IDX_W-1:0]    mem_wr_dword_out,
    output reg  [`DWORD_W-1:0]     mem_wr_data_out,
    output reg  [`SLOT_W-1:0]      tail_out,
    output reg                     expected_phase_out
);
    // ------------------------------------------------------------------
    // status assembly
    // ------------------------------------------------------------------
    // lowest detail wins
    // a plain scan suits four sources; with no hit the all-ones code
    // stands, so a failure should always name at least one source
    reg [`DETAIL_W-1:0] detail_min;
    reg [`DETAIL_W-1:0] code_i;
    integer             i;
    always @* begin
        detail_min = `DETAIL_NONE;
        code_i     = `DETAIL_NONE;
        for (i = 0; i < `DETAIL_SRC; i = i + 1) begin
            code_i = detail_codes_in[i*`DETAIL_W +: `DETAIL_W];
            if (detail_hit_in[i] && code_i < detail_min) begin
                detail_min = code_i;
            end
        end
    end

    // pack hint, log, kind, detail
    // reserved bits stay zero; a clean completion ignores hint, log
    // and kind so stray inputs cannot leak into the host's view
    reg [`STATUS_W-1:0] status_bits;
    always @* begin
        status_bits = `STATUS_OK;
        if (cpl_failed_in) begin
            status_bits[`NO_RETRY_POS]           = no_retry_hint_in;
            status_bits[`MORE_LOG_POS]           = more_log_in;
            status_bits[`KIND_HI:`KIND_LO]       = status_kind_in;
            status_bits[`DETAIL_HI:`DETAIL_LO]   = detail_min;
        end
    end

    // ------------------------------------------------------------------
    // entry build, phase left as zero and inserted at post time
    // ------------------------------------------------------------------
    reg [`DWORD_W-1:0] dw0;
    reg [`DWORD_W-1:0] dw2;
    reg [`DWORD_W-1:0] dw3;
    always @* begin
        dw0 = cpl_has_result_in ? cpl_result_in : `ZERO_DW;
        dw2 = `ZERO_DW;
        dw3 = `ZERO_DW;
        dw2[`QID_HI:`QID_LO]     = issuing_queue_id_in;
        dw2[`HEAD_HI:`HEAD_LO]   = queue_head_snapshot_in;
        dw3[`STATUS_HI:`STATUS_LO] = status_bits;
        dw3[`TAG_HI:`TAG_LO]     = command_tag_in;
    end

    wire [`ENTRY_W-1:0] entry_in = {dw3, dw2, `ZERO_DW, dw0};

    // ------------------------------------------------------------------
    // buffering between controller and memory writer
    // whole entries are queued so the controller keeps going while host
    // memory stalls, for up to four completions
    // ------------------------------------------------------------------
    wire [`ENTRY_W-1:0] q_data;
    wire                q_valid;
    reg                 q_pop;
    entry_fifo #(
        .WIDTH (`ENTRY_W),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_AW)
    ) u_fifo (
        .sys_clk_in   (sys_clk_in),
        .rstn_in      (rstn_in),
        .wr_data_in   (entry_in),
        .wr_valid_in  (cpl_valid_in & run_bit_in),
        .wr_ready_out (cpl_ready_out),
        .rd_data_out  (q_data),
        .rd_valid_out (q_valid),
        .rd_ready_in  (q_pop)
    );

    // ------------------------------------------------------------------
    // poster: one dword per accepted beat, dword 3 last
    // dword 3 goes last so the host never sees a new phase on a half entry
    // ------------------------------------------------------------------
    localparam ST_IDLE = 1'b0;
    localparam ST_SEND = 1'b1;
    reg                  state_q;
    reg [`DW_IDX_W-1:0]  dw_idx_q;
    reg                  run_q;
    wire                 beat_done = mem_wr_valid_out & mem_wr_ready_in;

    reg [`DWORD_W-1:0] next_word;
    always @* begin
        case (dw_idx_q)
            2'h0:    next_word = q_data[1*`DWORD_W-1:0];
            2'h1:    next_word = q_data[2*`DWORD_W-1:1*`DWORD_W];
            2'h2:    next_word = q_data[3*`DWORD_W-1:2*`DWORD_W];
            default: begin
                next_word = q_data[4*`DWORD_W-1:3*`DWORD_W];
                // phase from expected bit
                // forced after the fifo, so a rearm also covers entries
                // that were queued before it
                next_word[`PHASE_BIT] = expected_phase_out;
            end
        endcase
    end

    // pop only once the phase-carrying dword is accepted
    // popping earlier would free the entry while dword 3 may still stall
    always @* begin
        q_pop = (state_q == ST_SEND) & beat_done & (mem_wr_dword_out == `DW_LAST);
    end

    // a run bit drop lets the entry in flight finish, then holds the
    // queue; a rise rearms tail and phase for a fresh pass
    // limitation: raise the run bit again only once posting has stopped
    always @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            state_q            <= ST_IDLE;
            dw_idx_q           <= {`DW_IDX_W{1'b0}};
            run_q              <= 1'b0;
            mem_wr_valid_out   <= 1'b0;
            mem_wr_slot_out    <= `SLOT_ZERO;
            mem_wr_dword_out   <= {`DW_IDX_W{1'b0}};
            mem_wr_data_out    <= `ZERO_DW;
            tail_out           <= `SLOT_ZERO;
            expected_phase_out <= 1'b1;
        end else begin
            run_q <= run_bit_in;
            if (run_bit_in & ~run_q) begin
                tail_out           <= `SLOT_ZERO;
                expected_phase_out <= 1'b1;
            end
            case (state_q)
                ST_IDLE: begin
                    // first dword leaves the cycle after an entry is queued
                    if (q_valid & run_q) begin
                        mem_wr_valid_out <= 1'b1;
                        mem_wr_slot_out  <= tail_out;
                        mem_wr_dword_out <= dw_idx_q;
                        mem_wr_data_out  <= next_word;
                        dw_idx_q         <= dw_idx_q + 1'b1;
                        state_q          <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (beat_done) begin
                        if (mem_wr_dword_out == `DW_LAST) begin
                            mem_wr_valid_out <= 1'b0;
                            dw_idx_q         <= {`DW_IDX_W{1'b0}};
                            state_q          <= ST_IDLE;
                            // wrap flips phase
                            // ring_last_slot_in must hold steady while running
                            if (tail_out == ring_last_slot_in) begin
                                tail_out           <= `SLOT_ZERO;
                                expected_phase_out <= ~expected_phase_out;
                            end else begin
                                tail_out <= tail_out + 1'b1;
                            end
                        end else begin
                            mem_wr_dword_out <= dw_idx_q;
                            mem_wr_data_out  <= next_word;
                            dw_idx_q         <= dw_idx_q + 1'b1;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

//--- verification/completion_entry_poster_properties.sv
// port assertions for the completion entry poster
`include "completion_entry_poster_defines.vh"
module completion_entry_poster_checker (
    input wire                 sys_clk_in,
    input wire                 rstn_in,
    input wire                 run_bit_in,
    input wire [`SLOT_W-1:0]   ring_last_slot_in,
    input wire                 mem_wr_valid_out,
    input wire                 mem_wr_ready_in,
    input wire [`SLOT_W-1:0]   mem_wr_slot_out,
    input wire [`DW_IDX_W-1:0] mem_wr_dword_out,
    input wire [`DWORD_W-1:0]  mem_wr_data_out,
    input wire [`SLOT_W-1:0]   tail_out,
    input wire                 expected_phase_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);
    // one dword accepted by host memory
    wire acc = mem_wr_valid_out && mem_wr_ready_in;
    wire last = acc && mem_wr_dword_out == 2'h3;
    a_write_held: assert property (mem_wr_valid_out && !mem_wr_ready_in |=> mem_wr_valid_out
        && $stable(mem_wr_data_out) && $stable(mem_wr_dword_out) && $stable(mem_wr_slot_out))
        else $error("dword write changed before acceptance");
    a_dword_step: assert property (acc && mem_wr_dword_out != 2'h3 |=> mem_wr_valid_out
        && mem_wr_dword_out == $past(mem_wr_dword_out) + 2'h1) else $error("dword order broken");
    a_entry_gap: assert property (last |=> !mem_wr_valid_out)
        else $error("no idle cycle after entry");
    a_dword1_zero: assert property (mem_wr_valid_out && mem_wr_dword_out == 2'h1
        |-> mem_wr_data_out == 32'h00000000) else $error("dword 1 not zero");
    a_phase_field: assert property (mem_wr_valid_out && mem_wr_dword_out == 2'h3
        |-> mem_wr_data_out[16] == expected_phase_out) else $error("phase bit wrong");
    a_tail_step: assert property (last && mem_wr_slot_out != ring_last_slot_in
        |=> tail_out == $past(mem_wr_slot_out) + 16'h0001) else $error("tail did not step");
    a_wrap_flip: assert property (last && mem_wr_slot_out == ring_last_slot_in
        |=> tail_out == 16'h0000 && expected_phase_out != $past(expected_phase_out))
        else $error("wrap did not flip phase");
    a_slot_tail: assert property (mem_wr_valid_out |-> mem_wr_slot_out == tail_out)
        else $error("slot differs from tail");
    a_run_rearm: assert property ($rose(run_bit_in) |-> ##[1:2]
        (tail_out == 16'h0000 && expected_phase_out)) else $error("run did not rearm ring");
endmodule
bind completion_entry_poster completion_entry_poster_checker completion_entry_poster_checker_i (.*);

//--- verification/ring_host.sv
// host memory model taking dword writes and keeping slot phases
module ring_host (
    input  wire        sys_clk_in,
    input  wire        run_in,
    input  wire [1:0]  stall_in,
    input  wire        wr_valid_in,
    input  wire [15:0] wr_slot_in,
    input  wire [1:0]  wr_dword_in,
    input  wire [31:0] wr_data_in,
    output reg         ready_out = 1'b0,
    output wire        phase_new_out
);
    timeunit 1ns;
    timeprecision 100ps;
    reg   phase_q [0:15];
    reg   [7:0] lfsr_q = 8'hA5;
    // a posted entry must invert what the slot held
    assign phase_new_out = wr_data_in[16] != phase_q[wr_slot_in[3:0]];
    // ready: 0 prompt, 1 random slow, 2 held off
    always @(posedge sys_clk_in) begin
        lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
        ready_out <= stall_in == 2'h0 || (stall_in == 2'h1 && lfsr_q[0]);
        // phases cleared while the controller is stopped
        for (int i = 0; i < 16; i++) if (!run_in) phase_q[i] <= 1'b0;
        if (run_in && wr_valid_in && ready_out && wr_dword_in == 2'h3)
            phase_q[wr_slot_in[3:0]] <= wr_data_in[16];
    end
endmodule

//--- verification/testbench.sv
// self-checking bench for the completion entry poster
`include "completion_entry_poster_defines.vh"
`define CHK(nm, e, g) begin total_checks++; if ((e) !== (g)) begin n_mismatch++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        sys_clk_in = 1'b0, rstn_in = 1'b0, run_bit_in = 1'b0, cpl_valid_in = 1'b0;
    logic [15:0] ring_last_slot_in = 16'h0002, issuing_queue_id_in = 16'h0000;
    logic [15:0] queue_head_snapshot_in = 16'h0000, command_tag_in = 16'h0000;
    logic        cpl_has_result_in = 1'b0, cpl_failed_in = 1'b0;
    logic        no_retry_hint_in = 1'b0, more_log_in = 1'b0;
    logic [31:0] cpl_result_in = 32'h00000000, detail_codes_in = 32'h00000000;
    logic [2:0]  status_kind_in = 3'h0;
    logic [3:0]  detail_hit_in = 4'h0;
    logic [1:0]  stall = 2'h0, exp_dw = 2'h0, mem_wr_dword_out;
    wire         cpl_ready_out, mem_wr_valid_out, mem_wr_ready_in, expected_phase_out, ph_new;
    wire  [15:0] mem_wr_slot_out, tail_out;
    wire  [31:0] mem_wr_data_out;
    int          n_mismatch = 0, total_checks = 0, cycles = 0;
    logic [127:0] exp_q[$], cur, e;
    logic [15:0] exp_slot = 16'h0000;
    logic        exp_phase = 1'b1;
    logic [31:0] seed = 32'hEB19;
    completion_entry_poster completion_entry_poster_i (.*);
    ring_host ring_host_i (.sys_clk_in(sys_clk_in), .run_in(run_bit_in), .stall_in(stall),
        .wr_valid_in(mem_wr_valid_out), .wr_slot_in(mem_wr_slot_out),
        .wr_dword_in(mem_wr_dword_out), .wr_data_in(mem_wr_data_out),
        .ready_out(mem_wr_ready_in), .phase_new_out(ph_new));
    always #10 sys_clk_in = ~sys_clk_in;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // lowest applicable detail code, none gives FF
    function automatic logic [7:0] lowest(logic [3:0] hit, logic [31:0] c);
        logic [7:0] m;
        m = 8'hFF;
        for (int i = 0; i < 4; i++) if (hit[i] && c[8*i +: 8] < m) m = c[8*i +: 8];
        return m;
    endfunction
    task finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // offer one completion, note its entry once taken; enter and leave at a rising edge
    task automatic send(logic fail, logic [2:0] kind, logic [3:0] hit);
        logic [14:0] st;
        #1 cpl_valid_in = 1'b1;
        cpl_result_in = rnd();
        {issuing_queue_id_in, queue_head_snapshot_in} = rnd();
        {command_tag_in, detail_codes_in[15:0]} = rnd();
        detail_codes_in[31:16] = rnd();
        {cpl_has_result_in, no_retry_hint_in, more_log_in} = rnd();
        {cpl_failed_in, status_kind_in, detail_hit_in} = {fail, kind, hit};
        st = fail ? {no_retry_hint_in, more_log_in, 2'b00, kind, lowest(hit, detail_codes_in)} : 0;
        do @(negedge sys_clk_in); while (cpl_ready_out !== 1'b1 || !run_bit_in);
        @(posedge sys_clk_in);
        exp_q.push_back({st, 1'b0, command_tag_in, issuing_queue_id_in, queue_head_snapshot_in,
            32'h00000000, cpl_has_result_in ? cpl_result_in : 32'h00000000});
    endtask
    task idle(int n);
        #1 cpl_valid_in = 1'b0;
        repeat (n) @(posedge sys_clk_in);
    endtask
    // watcher: gathers accepted dwords and compares each whole entry
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles > 20000) begin
            n_mismatch++;
            finish_test();
        end else if (rstn_in && mem_wr_valid_out && mem_wr_ready_in) begin
            `CHK("slot", exp_slot, mem_wr_slot_out) // slot follows tail
            `CHK("dword index", exp_dw, mem_wr_dword_out) // dword order
            cur[32*exp_dw +: 32] = mem_wr_data_out;
            if (exp_dw == 2'h3) begin
                e = exp_q.pop_front();
                `CHK("phase", exp_phase, mem_wr_data_out[16]) // phase per pass
                `CHK("phase inverted", 1'b1, ph_new) // slot value inverted
                `CHK("tail", exp_slot, tail_out) // tail names the slot
                `CHK("expected phase", exp_phase, expected_phase_out) // phase per pass
                cur[112] = 1'b0;
                `CHK("entry", e, cur) // entry fields
                exp_phase ^= exp_slot == ring_last_slot_in;
                exp_slot = exp_slot == ring_last_slot_in ? 16'h0000 : exp_slot + 16'h0001;
            end
            exp_dw++;
        end
    end
    initial begin
        repeat (6) @(posedge sys_clk_in);
        #1 rstn_in = 1'b1;
        run_bit_in = 1'b1;
        @(posedge sys_clk_in);
        // every kind, many hit sets, back to back; 22 entries in all leave
        // the tail mid-ring on an even pass so the later rearm shows
        for (int k = 0; k < 14; k++) send(k != 1, k[2:0], 4'((k * 7) % 16));
        idle(80);
        `CHK("drained", 0, exp_q.size()) // one entry per completion
        $display("test kinds done");
        stall <= 2'h2;
        repeat (4) send(1'b1, 3'h7, 4'hF);
        @(negedge sys_clk_in);
        `CHK("ready when full", 1'b0, cpl_ready_out) // entries held whole
        @(posedge sys_clk_in) stall <= 2'h1;
        repeat (4) send(1'b0, 3'h0, 4'h0);
        idle(150);
        `CHK("drained", 0, exp_q.size()) // stalled entries posted
        $display("test stall done");
        // offers while stopped are ignored; restart rearms a one-slot ring
        @(posedge sys_clk_in);
        #1 run_bit_in = 1'b0;
        cpl_valid_in = 1'b1;
        repeat (5) @(posedge sys_clk_in);
        idle(1);
        #1 run_bit_in = 1'b1;
        ring_last_slot_in = 16'h0000;
        @(posedge sys_clk_in);
        exp_slot = 16'h0000;
        exp_phase = 1'b1;
        repeat (5) send(1'b1, 3'h2, 4'h6);
        idle(150);
        `CHK("drained", 0, exp_q.size()) // rearm and wrap
        $display("test rearm done");
        finish_test();
    end
endmodule
